//--- hw/tcd_cfg.svh
// Register offsets, field positions and timing counts of the tape unit
`ifndef TCD_CFG_SVH
`define TCD_CFG_SVH
// Register indices; byte address is four times the index
`define TCD_IDX_RD_START 8'h30
`define TCD_IDX_RD_COUNT 8'h31
`define TCD_IDX_RD_END 8'h32
`define TCD_IDX_WR_START 8'h34
`define TCD_IDX_WR_COUNT 8'h35
`define TCD_IDX_WR_END 8'h36
`define TCD_IDX_CMD 8'h38
`define TCD_IDX_IND 8'h39
`define TCD_IDX_IND_CLR 8'h3a
`define TCD_RST_PARAM 24'h000000
// Command register fields
`define TCD_CMD_OP_LSB 0
`define TCD_CMD_ADV_BIT 3
`define TCD_CMD_BIN_BIT 4
`define TCD_CMD_LOW_BIT 5
`define TCD_CMD_BUSY_BIT 8
`define TCD_CMD_ERR_BIT 9
// Indicator detail codes
`define TCD_IND_MARK 12'o0001
`define TCD_IND_EOT 12'o0002
`define TCD_IND_TPAR 12'o0040
`define TCD_IND_MPAR 12'o0100
`define TCD_IND_NRDY 12'o1000
`define TCD_IND_BUSY 12'o2000
`define TCD_IND_OVLD 12'o4000
// Tape mark character
`define TCD_MARK_CHAR 7'h0f
// Timing
`define TCD_CLK_HZ 10000000
`define TCD_RATE_LO_HZ 22500
`define TCD_RATE_HI_HZ 62500
`define TCD_ERASE_MILLIINCH 5000
`define TCD_SPEED_MILLIINCH_S 112500
`define TCD_EOR_BLANKS 2
`endif

//--- hw/tcd_pkg.sv
// Types of the tape control unit
package tcd_pkg;
  typedef enum logic [2:0] {
    TCD_OP_NONE = 3'h0,
    TCD_OP_READ = 3'h1,
    TCD_OP_WRITE = 3'h2,
    TCD_OP_MARK = 3'h3,
    TCD_OP_ERASE = 3'h4,
    TCD_OP_REWIND = 3'h5,
    TCD_OP_UNLOAD = 3'h6
  } tcd_op_type;
  typedef enum logic [3:0] {
    TCD_ST_IDLE = 4'h0,
    TCD_ST_READ = 4'h1,
    TCD_ST_FETCH = 4'h2,
    TCD_ST_WAIT = 4'h3,
    TCD_ST_CHAR = 4'h4,
    TCD_ST_BLANK = 4'h5,
    TCD_ST_LRC = 4'h6,
    TCD_ST_ERASE = 4'h7,
    TCD_ST_FINISH = 4'h8
  } tcd_state_type;
endpackage : tcd_pkg

//--- hw/tcd_dma.sv
// Seven-track tape control unit with character DMA
//
// Function
// - One read or one write at a time
// - Translated even parity, binary odd parity
// - Tape mark only as one-character record
// - Command writes single tape mark block
// - Skip-erase moves tape five inches
// - Check vertical parity; generate when writing
// - Longitudinal parity after two blanks
// - Longitudinal character never stored
// - Low or high density character rate
// - Load address and count on accept
// - Per character: access, increment, decrement
// - Stop storing at zero count or gap
// - Tape keeps moving until gap
// - Final address into end pointer
// - Advance option updates start pointer
// - Start pointer updated only without error
// - End pointer written even on error
// - Write ends at zero count or fault
// - Rewind; request while rewinding flags busy
// - Lockout rewind; requests flag not ready
// - Indicators at octal detail codes
// - Two channels, three parameter words each
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "tcd_cfg.svh"
module tcd_dma
  import tcd_pkg::*;
#(
  parameter int ERASE_CYCLES = (`TCD_ERASE_MILLIINCH * (`TCD_CLK_HZ / 1000))
                               / (`TCD_SPEED_MILLIINCH_S / 1000)
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  output logic [23:0] mem_addr,
  output logic [5:0] mem_wdata,
  output logic mem_req,
  output logic mem_we,
  input wire logic [5:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic mem_perr,
  input wire logic tape_strobe,
  input wire logic [6:0] tape_rdata,
  input wire logic tape_gap,
  input wire logic tape_eot,
  input wire logic tape_ready,
  input wire logic tape_rewinding,
  input wire logic tape_loaded,
  input wire logic tape_fault,
  output logic [6:0] tape_wdata,
  output logic tape_wstrobe,
  output logic tape_run,
  output logic tape_write,
  output logic tape_erase,
  output logic tape_rewind,
  output logic tape_unload,
  output logic tape_low_density
);
  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int PER_LO = `TCD_CLK_HZ / `TCD_RATE_LO_HZ;
  localparam int PER_HI = `TCD_CLK_HZ / `TCD_RATE_HI_HZ;
  localparam logic [8:0] PER_LO_C = PER_LO[8:0];
  localparam logic [8:0] PER_HI_C = PER_HI[8:0];
  localparam logic [23:0] ERASE_C = ERASE_CYCLES[23:0];
  localparam int NSYNC = 14;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic strobe_d_r;
  wire [NSYNC-1:0] pins = {tape_strobe, tape_rdata, tape_gap, tape_eot,
                           tape_ready, tape_rewinding, tape_loaded,
                           tape_fault};
  wire s_strobe = sync2_r[13];
  wire [6:0] s_data = sync2_r[12:6];
  wire s_gap = sync2_r[5];
  wire s_eot = sync2_r[4];
  wire s_ready = sync2_r[3];
  wire s_rewinding = sync2_r[2];
  wire s_loaded = sync2_r[1];
  wire s_fault = sync2_r[0];
  wire char_in = s_strobe & ~strobe_d_r;

  // Two flops before any logic reads a pin
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      strobe_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      strobe_d_r <= s_strobe;
    end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [23:0] rd_start_r, rd_count_r, rd_end_r;
  logic [23:0] wr_start_r, wr_count_r, wr_end_r;
  logic [11:0] ind_r, ind_hit_r;
  logic [23:0] addr_r, count_r, tmr_big_r;
  logic [8:0] tmr_r;
  logic [6:0] held_r, first_r, lrc_r, char_r;
  logic [1:0] chars_r, blank_r;
  logic adv_r, bin_r, low_r, wchan_r, err_r, lock_r, held_ok_r;
  logic fin_r;
  tcd_state_type state_r;
  tcd_op_type op_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire idle = (state_r == TCD_ST_IDLE);
  wire wr_cmd = reg_wr & (reg_addr == `TCD_IDX_CMD);
  wire wr_clr = reg_wr & (reg_addr == `TCD_IDX_IND_CLR);
  wire [2:0] cmd_op = reg_wdata[`TCD_CMD_OP_LSB +: 3];
  wire cmd_bad_busy = s_rewinding;
  wire cmd_bad_nrdy = lock_r | ~s_ready;
  wire accept = wr_cmd & idle & (cmd_op != 3'h0) & ~cmd_bad_busy
                & ~cmd_bad_nrdy;
  wire tick = (tmr_r == 9'h000);
  wire [8:0] period = low_r ? PER_LO_C : PER_HI_C;
  wire par_odd = bin_r;
  wire rd_par_bad = ((^s_data) != par_odd);
  wire [6:0] out_char = {(^char_r[5:0]) ^ par_odd, char_r[5:0]};
  wire [23:0] status = {14'h0000, err_r, ~idle, 2'b00, low_r, bin_r,
                        adv_r, op_r};

  // Read data answer, one cycle later; unmapped reads as zero
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      reg_rdata <= '0;
    else if (clk_en)
    begin
      if (!reg_rd)
        reg_rdata <= '0;
      else
        case (reg_addr)
          `TCD_IDX_RD_START: reg_rdata <= rd_start_r;
          `TCD_IDX_RD_COUNT: reg_rdata <= rd_count_r;
          `TCD_IDX_RD_END: reg_rdata <= rd_end_r;
          `TCD_IDX_WR_START: reg_rdata <= wr_start_r;
          `TCD_IDX_WR_COUNT: reg_rdata <= wr_count_r;
          `TCD_IDX_WR_END: reg_rdata <= wr_end_r;
          `TCD_IDX_CMD: reg_rdata <= status;
          `TCD_IDX_IND: reg_rdata <= {12'h000, ind_r};
          default: reg_rdata <= '0;
        endcase
    end

  // ----------------------------------------------------------------
  // Parameter words of both channels
  // ----------------------------------------------------------------
  // Software writes start and count; hardware write-back at the end of a transfer
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      rd_start_r <= `TCD_RST_PARAM;
      rd_count_r <= `TCD_RST_PARAM;
      rd_end_r <= `TCD_RST_PARAM;
      wr_start_r <= `TCD_RST_PARAM;
      wr_count_r <= `TCD_RST_PARAM;
      wr_end_r <= `TCD_RST_PARAM;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == `TCD_IDX_RD_START)
        rd_start_r <= reg_wdata;
      if (reg_wr && reg_addr == `TCD_IDX_RD_COUNT)
        rd_count_r <= reg_wdata;
      if (reg_wr && reg_addr == `TCD_IDX_WR_START)
        wr_start_r <= reg_wdata;
      if (reg_wr && reg_addr == `TCD_IDX_WR_COUNT)
        wr_count_r <= reg_wdata;
      if (fin_r && !wchan_r)
      begin
        rd_end_r <= addr_r;
        if (adv_r && !err_r)
          rd_start_r <= addr_r;
      end
      if (fin_r && wchan_r)
      begin
        wr_end_r <= addr_r;
        if (adv_r && !err_r)
          wr_start_r <= addr_r;
      end
    end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  // Sticky; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      ind_r <= '0;
    else if (clk_en)
      ind_r <= (ind_r & ~(wr_clr ? reg_wdata[11:0] : 12'h000))
               | ind_hit_r | (s_eot ? `TCD_IND_EOT : 12'h000);

  // Lockout held until operator reloads
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      lock_r <= 1'b0;
    else if (clk_en)
    begin
      if (accept && cmd_op == TCD_OP_UNLOAD)
        lock_r <= 1'b1;
      else if (s_loaded)
        lock_r <= 1'b0;
    end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      state_r <= TCD_ST_IDLE;
      op_r <= TCD_OP_NONE;
      {adv_r, bin_r, low_r, wchan_r, err_r, held_ok_r, fin_r} <= '0;
      {addr_r, count_r, tmr_big_r} <= '0;
      {held_r, first_r, lrc_r, char_r} <= '0;
      {chars_r, blank_r, tmr_r} <= '0;
      ind_hit_r <= '0;
      {mem_addr, mem_wdata, mem_req, mem_we} <= '0;
      {tape_wdata, tape_wstrobe, tape_rewind, tape_unload} <= '0;
    end
    else if (clk_en)
    begin
      ind_hit_r <= '0;
      {mem_req, mem_we, tape_wstrobe, fin_r} <= '0;
      {tape_rewind, tape_unload} <= '0;
      // Reload one short so ticks fall exactly one period apart
      tmr_r <= tick ? period - 9'h001 : tmr_r - 9'h001;
      // Refused request on a busy or locked drive
      if (wr_cmd && cmd_bad_busy)
        ind_hit_r <= `TCD_IND_BUSY;
      else if (wr_cmd && cmd_bad_nrdy)
        ind_hit_r <= `TCD_IND_NRDY;
      // Echo or read-back parity check while tape moves
      if (state_r != TCD_ST_IDLE && char_in && rd_par_bad)
      begin
        ind_hit_r <= `TCD_IND_TPAR;
        err_r <= 1'b1;
      end
      case (state_r)
        TCD_ST_IDLE:
          if (accept)
          begin
            op_r <= tcd_op_type'(cmd_op);
            adv_r <= reg_wdata[`TCD_CMD_ADV_BIT];
            bin_r <= reg_wdata[`TCD_CMD_BIN_BIT];
            low_r <= reg_wdata[`TCD_CMD_LOW_BIT];
            {err_r, held_ok_r, chars_r, lrc_r} <= '0;
            tmr_r <= 9'h000;
            wchan_r <= (cmd_op != TCD_OP_READ);
            case (tcd_op_type'(cmd_op))
              TCD_OP_READ:
              begin
                addr_r <= rd_start_r;
                count_r <= rd_count_r;
                state_r <= TCD_ST_READ;
              end
              TCD_OP_WRITE:
              begin
                addr_r <= wr_start_r;
                count_r <= wr_count_r;
                state_r <= TCD_ST_FETCH;
              end
              TCD_OP_MARK:
              begin
                char_r <= `TCD_MARK_CHAR;
                count_r <= '0;
                addr_r <= wr_start_r;
                state_r <= TCD_ST_CHAR;
              end
              TCD_OP_ERASE:
              begin
                tmr_big_r <= ERASE_C;
                state_r <= TCD_ST_ERASE;
              end
              TCD_OP_REWIND:
                tape_rewind <= 1'b1;
              TCD_OP_UNLOAD:
              begin
                tape_rewind <= 1'b1;
                tape_unload <= 1'b1;
              end
              default: state_r <= TCD_ST_IDLE;
            endcase
          end
        TCD_ST_READ:
        begin
          if (char_in)
          begin
            // Store the held character; the newest may be the check
            if (held_ok_r && count_r != 24'h000000)
            begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= addr_r;
              mem_wdata <= held_r[5:0];
              addr_r <= addr_r + 24'h000001;
              count_r <= count_r - 24'h000001;
              if (addr_r == 24'hffffff)
                ind_hit_r <= `TCD_IND_OVLD;
            end
            held_r <= s_data;
            held_ok_r <= 1'b1;
            lrc_r <= lrc_r ^ s_data;
            if (chars_r == 2'd0)
              first_r <= s_data;
            if (chars_r != 2'd3)
              chars_r <= chars_r + 2'd1;
          end
          else if (s_gap && held_ok_r)
          begin
            // Gap: held character is the check and is dropped
            if (lrc_r != 7'h00)
            begin
              ind_hit_r <= `TCD_IND_TPAR;
              err_r <= 1'b1;
            end
            if (chars_r == 2'd2 && first_r == `TCD_MARK_CHAR)
              ind_hit_r <= `TCD_IND_MARK;
            state_r <= TCD_ST_FINISH;
          end
        end
        TCD_ST_FETCH:
          if (s_fault)
          begin
            err_r <= 1'b1;
            state_r <= TCD_ST_FINISH;
          end
          else if (count_r == 24'h000000)
          begin
            blank_r <= 2'(`TCD_EOR_BLANKS);
            state_r <= TCD_ST_BLANK;
          end
          else
          begin
            mem_req <= 1'b1;
            mem_addr <= addr_r;
            state_r <= TCD_ST_WAIT;
          end
        TCD_ST_WAIT:
          if (mem_rvalid)
          begin
            char_r <= {1'b0, mem_rdata};
            addr_r <= addr_r + 24'h000001;
            count_r <= count_r - 24'h000001;
            if (mem_perr)
            begin
              ind_hit_r <= `TCD_IND_MPAR;
              err_r <= 1'b1;
            end
            state_r <= TCD_ST_CHAR;
          end
        TCD_ST_CHAR:
          if (tick)
          begin
            tape_wdata <= out_char;
            tape_wstrobe <= 1'b1;
            lrc_r <= lrc_r ^ out_char;
            state_r <= TCD_ST_FETCH;
          end
        TCD_ST_BLANK:
          if (tick)
          begin
            blank_r <= blank_r - 2'd1;
            if (blank_r == 2'd1)
              state_r <= TCD_ST_LRC;
          end
        TCD_ST_LRC:
          if (tick)
          begin
            tape_wdata <= lrc_r;
            tape_wstrobe <= 1'b1;
            state_r <= TCD_ST_FINISH;
          end
        TCD_ST_ERASE:
        begin
          tmr_big_r <= tmr_big_r - 24'h000001;
          if (tmr_big_r == 24'h000001)
            state_r <= TCD_ST_IDLE;
        end
        TCD_ST_FINISH:
        begin
          fin_r <= (op_r != TCD_OP_MARK);
          state_r <= TCD_ST_IDLE;
        end
        default: state_r <= TCD_ST_IDLE;
      endcase
    end

  // ----------------------------------------------------------------
  // Drive controls
  // ----------------------------------------------------------------
  assign tape_run = ~idle & (state_r != TCD_ST_FINISH);
  assign tape_write = tape_run & wchan_r & (state_r != TCD_ST_ERASE);
  assign tape_erase = (state_r == TCD_ST_ERASE);
  assign tape_low_density = low_r;
endmodule : tcd_dma

//--- test/tcd_dma_assertions.sv
// Port checks for the tape control unit
`timescale 1ns/1ps
module tcd_dma_checker
#(
  parameter int ERASE_CYCLES = 20
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_rd,
  input wire logic [23:0] reg_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic tape_run,
  input wire logic tape_write,
  input wire logic tape_erase,
  input wire logic tape_wstrobe,
  input wire logic tape_rewind,
  input wire logic tape_unload
);
  int erase_cnt_r;
  // Length of the current erase run
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      erase_cnt_r <= 0;
    else
      erase_cnt_r <= tape_erase ? erase_cnt_r + 1 : 0;
  end
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (reset);
  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  a_rw_exclusive: assert property (tape_write |-> !mem_we)
    else $error("memory store during tape write");
  a_erase_moves: assert property (tape_erase |-> tape_run)
    else $error("erase without tape motion");
  a_erase_length: assert property
    ($fell(tape_erase) |-> erase_cnt_r == ERASE_CYCLES)
    else $error("erase run of wrong length");
  a_strobe_spacing: assert property
    (tape_wstrobe |=> !tape_wstrobe[*8])
    else $error("write strobes too close");
  a_store_request: assert property (mem_we |-> mem_req)
    else $error("store without memory request");
  a_store_moving: assert property (mem_we |-> tape_run)
    else $error("store while tape stopped");
  a_rewind_pulse: assert property (tape_rewind |=> !tape_rewind)
    else $error("rewind pulse too long");
  a_unload_pulse: assert property (tape_unload |=> !tape_unload)
    else $error("unload pulse too long");
  a_rdata_idle: assert property
    (!$past(reg_rd) |-> reg_rdata == 24'h000000)
    else $error("read data outside answer cycle");
  // Main scenarios reached
  c_erase: cover property ($fell(tape_erase));
  c_store: cover property (mem_we);
  c_wstrobe: cover property (tape_wstrobe);
  c_unload: cover property (tape_unload);
endmodule : tcd_dma_checker
bind tcd_dma tcd_dma_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (
  .sys_clk, .reset, .reg_rd, .reg_rdata, .mem_req, .mem_we, .tape_run,
  .tape_write, .tape_erase, .tape_wstrobe, .tape_rewind, .tape_unload);

//--- test/tcd_tape_model.sv
// Behavioural seven-track tape drive for the bench
`timescale 1ns/1ps
module tcd_tape_model
(
  input wire logic sys_clk,
  input wire logic [6:0] tape_wdata,
  input wire logic tape_wstrobe,
  input wire logic tape_rewind,
  input wire logic tape_unload,
  input wire logic tape_run,
  output logic tape_strobe = 1'b0,
  output logic [6:0] tape_rdata = 7'h55,
  output logic tape_gap = 1'b1,
  output logic tape_eot = 1'b0,
  output logic tape_ready = 1'b1,
  output logic tape_rewinding = 1'b0,
  output logic tape_loaded = 1'b0,
  output logic tape_fault = 1'b0
);
  logic [6:0] blk [8];
  logic [6:0] wq [$];
  int wt [$];
  int blen = 0;
  int cyc = 0;
  logic run_ok = 1'b0;
  // Cycle count and capture of written characters
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (tape_wstrobe)
    begin
      wq.push_back(tape_wdata);
      wt.push_back(cyc);
    end
  end
  // Rewind keeps the drive busy for a while
  always @(posedge sys_clk)
  begin
    if (tape_rewind && !tape_unload)
    begin
      tape_rewinding <= 1'b1;
      repeat (100) @(posedge sys_clk);
      tape_rewinding <= 1'b0;
    end
  end
  // Lockout leaves the drive not ready until loaded
  always @(posedge sys_clk)
  begin
    if (tape_unload)
      tape_ready <= 1'b0;
  end
  // Operator reload
  task automatic load();
    @(posedge sys_clk);
    tape_loaded <= 1'b1;
    tape_ready <= 1'b1;
    @(posedge sys_clk);
    tape_loaded <= 1'b0;
  endtask : load
  // One block between gaps; data inverted once its hold runs out
  task automatic play();
    @(posedge sys_clk);
    tape_gap <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < blen; i++)
    begin
      tape_rdata <= blk[i];
      tape_strobe <= 1'b1;
      repeat (4) @(posedge sys_clk);
      tape_strobe <= 1'b0;
      repeat (2) @(posedge sys_clk);
      tape_rdata <= ~blk[i];
      repeat (8) @(posedge sys_clk);
    end
    run_ok = tape_run;
    tape_gap <= 1'b1;
  endtask : play
endmodule : tcd_tape_model

//--- test/tb_tape_control_dma.sv
// Self-checking bench for the tape control unit
`timescale 1ns/1ps
`include "tcd_cfg.svh"
module tb_tape_control_dma;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic [23:0] reg_rdata, mem_addr;
  logic [5:0] mem_rdata = 6'h00;
  logic [5:0] mem_wdata;
  logic mem_rvalid = 1'b0;
  logic mem_perr = 1'b0;
  logic perr_on = 1'b0;
  logic mem_req, mem_we, tape_strobe, tape_gap, tape_eot, tape_ready;
  logic tape_rewinding, tape_loaded, tape_fault, tape_wstrobe, tape_run;
  logic tape_write, tape_erase, tape_rewind, tape_unload, tape_low_density;
  logic [6:0] tape_rdata, tape_wdata;
  logic [5:0] mem [1024];
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int nst = 0;
  tcd_dma #(.ERASE_CYCLES(20)) dut_u (.*);
  tcd_tape_model tape_u (.*);
  always #50 sys_clk = ~sys_clk;
  // Memory answers one cycle after each fetch
  always @(posedge sys_clk)
  begin
    mem_rvalid <= mem_req && !mem_we;
    mem_perr <= mem_req && !mem_we && perr_on;
    mem_rdata <= mem[mem_addr[9:0]];
    if (mem_req && mem_we)
    begin
      mem[mem_addr[9:0]] <= mem_wdata;
      nst <= nst + 1;
    end
  end
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      stop_test();
    end
  end
  //----------------------------------------------------------------
  // Bus tasks and checks
  //----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      failures++;
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rchk
  task automatic idle();
    for (int i = 0; i < 3000 && dut_u.reg_rdata[8] !== 1'b0; i++)
      rchk(8'h3f, 24'h000000);
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge sys_clk);
      reg_addr <= `TCD_IDX_CMD;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 if (reg_rdata[8] === 1'b0) break;
    end
    chk(24'(reg_rdata[8]), 24'h000000);
  endtask : idle
  function automatic logic [6:0] par(input logic [5:0] d, input logic odd);
    return {^d ^ odd, d};
  endfunction : par
  //----------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------
  task automatic t_regs();
    rchk(`TCD_IDX_RD_END, 24'h000000);
    wr(`TCD_IDX_RD_END, 24'h000123);
    rchk(`TCD_IDX_RD_END, 24'h000000);
    wr(`TCD_IDX_WR_COUNT, 24'habcdef);
    rchk(`TCD_IDX_WR_COUNT, 24'habcdef);
    rchk(8'h3f, 24'h000000);
  endtask : t_regs
  task automatic t_read(input logic bad);
    logic [6:0] c1;
    c1 = {bad, 6'h12};
    tape_u.blk[0] = 7'h21;
    tape_u.blk[1] = c1;
    tape_u.blk[2] = 7'h33;
    tape_u.blk[3] = 7'h21 ^ c1 ^ 7'h33;
    tape_u.blen = 4;
    mem[256] = 6'h3f;
    nst = 0;
    wr(`TCD_IDX_RD_START, 24'h000100);
    wr(`TCD_IDX_RD_COUNT, 24'h000002);
    wr(`TCD_IDX_CMD, 24'h000009);
    wr(`TCD_IDX_CMD, 24'h000002);
    tape_u.play();
    idle();
    chk(24'(nst), 24'h000002);
    chk(24'(mem[256]), 24'h000021);
    chk(24'(mem[257]), 24'h000012);
    chk(24'(tape_u.run_ok), 24'h000001);
    rchk(`TCD_IDX_RD_END, 24'h000102);
    rchk(`TCD_IDX_RD_START, bad ? 24'h000100 : 24'h000102);
    rchk(`TCD_IDX_WR_END, 24'h000000);
    rchk(`TCD_IDX_IND, bad ? 24'(`TCD_IND_TPAR) : 24'h0);
    rchk(`TCD_IDX_IND, bad ? 24'(`TCD_IND_TPAR) : 24'h0);
    wr(`TCD_IDX_IND_CLR, 24'h000fff);
    rchk(`TCD_IDX_IND, 24'h000000);
  endtask : t_read
  task automatic t_mark(input int n, input logic [23:0] e);
    tape_u.blk[0] = 7'h0f;
    tape_u.blk[1] = 7'h0f;
    tape_u.blk[2] = 7'h00;
    tape_u.blen = n;
    wr(`TCD_IDX_RD_COUNT, 24'h000005);
    wr(`TCD_IDX_CMD, 24'h000001);
    tape_u.play();
    idle();
    rchk(`TCD_IDX_IND, e);
    wr(`TCD_IDX_IND_CLR, 24'h000fff);
  endtask : t_mark
  task automatic t_write(input logic low);
    int per;
    per = low ? 444 : 160;
    tape_u.wq.delete();
    tape_u.wt.delete();
    mem[512] = 6'h05;
    mem[513] = 6'h3c;
    // High-density run also sees memory parity errors
    perr_on <= !low;
    wr(`TCD_IDX_WR_START, 24'h000200);
    wr(`TCD_IDX_WR_COUNT, 24'h000002);
    wr(`TCD_IDX_CMD, {18'h0, low, 5'h1a});
    @(negedge sys_clk);
    chk(24'(tape_write), 24'h000001);
    idle();
    perr_on <= 1'b0;
    chk(24'(tape_low_density), 24'(low));
    chk(24'(tape_u.wq.size()), 24'h000003);
    chk(24'(tape_u.wq[0]), 24'(par(6'h05, 1'b1)));
    chk(24'(tape_u.wq[1]), 24'(par(6'h3c, 1'b1)));
    chk(24'(tape_u.wq[2]), 24'(par(6'h05, 1'b1) ^ par(6'h3c, 1'b1)));
    chk(24'(tape_u.wt[1] - tape_u.wt[0]), 24'(per));
    chk(24'(tape_u.wt[2] - tape_u.wt[1] > 2 * per), 24'h000001);
    rchk(`TCD_IDX_WR_END, 24'h000202);
    rchk(`TCD_IDX_WR_START, low ? 24'h000202 : 24'h000200);
    rchk(`TCD_IDX_IND, low ? 24'h0 : 24'(`TCD_IND_MPAR));
    wr(`TCD_IDX_IND_CLR, 24'h000fff);
  endtask : t_write
  // Write fault at the first fetch ends the block with error
  task automatic t_fault();
    tape_u.wq.delete();
    @(posedge sys_clk);
    tape_u.tape_fault <= 1'b1;
    wr(`TCD_IDX_WR_START, 24'h000200);
    wr(`TCD_IDX_CMD, 24'h00000a);
    idle();
    @(posedge sys_clk);
    tape_u.tape_fault <= 1'b0;
    chk(24'(tape_u.wq.size()), 24'h000000);
    rchk(`TCD_IDX_WR_END, 24'h000200);
    rchk(`TCD_IDX_WR_START, 24'h000200);
    rchk(`TCD_IDX_CMD, 24'h00020a);
  endtask : t_fault
  task automatic t_misc();
    int n;
    n = 0;
    tape_u.wq.delete();
    wr(`TCD_IDX_CMD, 24'h000003);
    idle();
    chk(24'(tape_u.wq[0]), 24'h00000f);
    chk(24'(tape_u.wq[1]), 24'h00000f);
    wr(`TCD_IDX_CMD, 24'h000004);
    for (int i = 0; i < 200; i++)
    begin
      @(negedge sys_clk);
      n += int'(tape_erase);
    end
    chk(24'(n), 24'h000014);
    wr(`TCD_IDX_CMD, 24'h000005);
    repeat (10) @(posedge sys_clk);
    wr(`TCD_IDX_CMD, 24'h000001);
    repeat (5) @(posedge sys_clk);
    rchk(`TCD_IDX_IND, 24'(`TCD_IND_BUSY));
    repeat (120) @(posedge sys_clk);
    wr(`TCD_IDX_IND_CLR, 24'h000fff);
    wr(`TCD_IDX_CMD, 24'h000006);
    repeat (10) @(posedge sys_clk);
    wr(`TCD_IDX_CMD, 24'h000001);
    repeat (5) @(posedge sys_clk);
    rchk(`TCD_IDX_IND, 24'(`TCD_IND_NRDY));
    tape_u.load();
    repeat (5) @(posedge sys_clk);
    wr(`TCD_IDX_IND_CLR, 24'h000fff);
    rchk(`TCD_IDX_IND, 24'h000000);
  endtask : t_misc
  task automatic stop_test();
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_read(1'b0);
    t_read(1'b1);
    t_mark(2, 24'(`TCD_IND_MARK));
    t_mark(3, 24'h000000);
    t_write(1'b1);
    t_write(1'b0);
    t_fault();
    t_misc();
    stop_test();
  end
endmodule : tb_tape_control_dma
